// ===== step_rate_ramp_scaling.sv
// Behaviour
// - velocity is signed, -2047 to 2047
// - microstep rate 16e6*v / (2^pdiv*2048*32)
// - pulse prescale 0..13, shared by ramp
// - fullstep rate is microstep rate / 2^exp
// - acceleration is unsigned, 0 to 2047
// - accel 16e6^2*a / 2^(rdiv+pdiv+29)
// - positioning accel bounded by divisor difference
// - positioning upper accel bound capped at 2047
// - velocity mode uses full accel range
// - microstep exponent resets to 8
`timescale 1ns/10ps
`default_nettype none
`include "step_rate_map.svh"

module step_rate_ramp_scaling (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [31:0] rdata_o,
  output var  logic        step_o,
  output var  logic        dir_o,
  output var  logic        fullstep_o,
  output var  logic        busy_o
);

  step_rate_pkg::cfg_t          cfg;
  step_rate_pkg::motion_state_t state;
  logic signed [31:0]           target;
  logic signed [31:0]           pos;
  logic signed [11:0]           v_act;
  logic [15:0]                  ref_acc;
  logic                         ref_tick;
  logic [29:0]                  vel_acc;
  logic [26:0]                  ramp_acc;
  logic                         ramp_carry;
  logic [10:0]                  acc_lo;
  logic [10:0]                  acc_hi;
  logic [10:0]                  acc_eff;
  logic signed [11:0]           v_goal;
  logic [11:0]                  v_mag;
  logic [29:0]                  vel_thr;
  logic [26:0]                  ramp_thr;
  logic [30:0]                  next_vel_acc;
  logic [27:0]                  next_ramp_acc;
  logic                         at_target;
  logic signed [31:0]           next_pos;
  logic [31:0]                  mstep_mask;

  // 2^e - dec, saturating at the 11-bit accel range
  function automatic logic [10:0] pow2_lim(input logic signed [5:0] e, input logic dec);
    logic [11:0] p;
    p = 12'h000;
    if (e < 6'sh00)
      pow2_lim = 11'h000;
    else if (e >= 6'sh0B)
      pow2_lim = `ACC_MAX;
    else
    begin
      p = 12'h001 << e[3:0];
      pow2_lim = p[10:0] - {10'h000, dec};
    end
  endfunction : pow2_lim

  function automatic logic [11:0] abs12(input logic signed [11:0] v);
    abs12 = v[11] ? 12'(-v) : 12'(v);
  endfunction : abs12

  // 16 MHz reference tick from the 25 MHz core clock
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ref_acc  <= 16'h0000;
      ref_tick <= 1'b0;
    end
    else if ({1'b0, ref_acc} + 17'(`REF_KHZ) >= 17'(`CLK_KHZ))
    begin
      ref_acc  <= 16'({1'b0, ref_acc} + 17'(`REF_KHZ) - 17'(`CLK_KHZ));
      ref_tick <= 1'b1;
    end
    else
    begin
      ref_acc  <= 16'({1'b0, ref_acc} + 17'(`REF_KHZ));
      ref_tick <= 1'b0;
    end
  end

  // configuration writes
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      cfg.mode      <= step_rate_pkg::mode_velocity;
      cfg.vel       <= 12'sh000;
      cfg.accel     <= 11'h000;
      cfg.pdiv      <= `PDIV_RST;
      cfg.rdiv      <= `RDIV_RST;
      cfg.mstep_exp <= `MSTEP_RST;
      target        <= 32'sh00000000;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `OFS_CTRL:
          cfg.mode <= step_rate_pkg::move_mode_t'(wdata_i[`CTRL_MODE_BIT]);
        `OFS_VEL:
          cfg.vel <= ($signed(wdata_i[11:0]) < `VEL_MIN) ? `VEL_MIN
                                                         : $signed(wdata_i[11:0]);
        `OFS_ACCEL:
          cfg.accel <= wdata_i[10:0];
        `OFS_PDIV:
          cfg.pdiv <= (wdata_i[3:0] > `PDIV_MAX) ? `PDIV_MAX : wdata_i[3:0];
        `OFS_RDIV:
          cfg.rdiv <= (wdata_i[3:0] > `RDIV_MAX) ? `RDIV_MAX : wdata_i[3:0];
        `OFS_MSTEP:
          cfg.mstep_exp <= (wdata_i[3:0] > `MSTEP_MAX) ? `MSTEP_MAX : wdata_i[3:0];
        `OFS_TARGET:
          target <= $signed(wdata_i);
        default:
          ;
      endcase
    end
  end

  // positioning accel window from divisor difference
  always_comb
  begin
    acc_lo = pow2_lim(6'($signed({2'b00, cfg.rdiv}) - $signed({2'b00, cfg.pdiv})
                        - `LIM_LO_OFS), 1'b0);
    acc_hi = pow2_lim(6'($signed({2'b00, cfg.rdiv}) - $signed({2'b00, cfg.pdiv})
                        + `LIM_HI_OFS), 1'b1);
    if (cfg.mode == step_rate_pkg::mode_velocity)
      acc_eff = cfg.accel;
    else if (cfg.accel < acc_lo)
      acc_eff = acc_lo;
    else if (cfg.accel > acc_hi)
      acc_eff = acc_hi;
    else
      acc_eff = cfg.accel;
  end

  // velocity goal
  always_comb
  begin
    at_target = (pos == target);
    v_goal    = 12'sh000;
    if (state == step_rate_pkg::st_run)
    begin
      if (cfg.mode == step_rate_pkg::mode_velocity)
        v_goal = cfg.vel;
      else if (!at_target)
        v_goal = (target > pos) ? $signed(abs12(cfg.vel)) : -$signed(abs12(cfg.vel));
    end
  end

  // motion state
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state <= step_rate_pkg::st_idle;
    else if (wr_i && addr_i == `OFS_CTRL && wdata_i[`CTRL_STOP_BIT])
      state <= step_rate_pkg::st_stop;
    else if (wr_i && addr_i == `OFS_CTRL && wdata_i[`CTRL_START_BIT])
      state <= step_rate_pkg::st_run;
    else
    begin
      case (state)
        step_rate_pkg::st_idle:
          ;
        step_rate_pkg::st_run:
          if (cfg.mode == step_rate_pkg::mode_position && at_target)
            state <= step_rate_pkg::st_idle;
        step_rate_pkg::st_stop:
          if (v_act == 12'sh000)
            state <= step_rate_pkg::st_idle;
        default:
          state <= step_rate_pkg::st_idle;
      endcase
    end
  end

  // ramp: one velocity unit per 2^(rdiv+13) accel units at 16 MHz
  always_comb
  begin
    ramp_thr      = 27'h0000001 << (`RAMP_BASE_BITS + 5'(cfg.rdiv));
    next_ramp_acc = {1'b0, ramp_acc} + {17'h00000, acc_eff};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ramp_acc   <= 27'h0000000;
      ramp_carry <= 1'b0;
    end
    else if (ref_tick && next_ramp_acc >= {1'b0, ramp_thr})
    begin
      ramp_acc   <= 27'(next_ramp_acc - {1'b0, ramp_thr});
      ramp_carry <= 1'b1;
    end
    else
    begin
      ramp_acc   <= ref_tick ? 27'(next_ramp_acc) : ramp_acc;
      ramp_carry <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      v_act <= 12'sh000;
    else if (cfg.mode == step_rate_pkg::mode_position && at_target
             && state == step_rate_pkg::st_run)
      v_act <= 12'sh000;
    else if (ramp_carry && v_act < v_goal)
      v_act <= v_act + 12'sh001;
    else if (ramp_carry && v_act > v_goal)
      v_act <= v_act - 12'sh001;
  end

  // step generation: overflow at 2^(pdiv+16) per 16 MHz tick
  always_comb
  begin
    v_mag        = abs12(v_act);
    vel_thr      = 30'h00000001 << (`VEL_FRAC_BITS + 5'(cfg.pdiv));
    next_vel_acc = {1'b0, vel_acc} + {19'h00000, v_mag};
    next_pos     = v_act[11] ? pos - 32'sh00000001 : pos + 32'sh00000001;
    mstep_mask   = (32'h00000001 << cfg.mstep_exp) - 32'h00000001;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      vel_acc    <= 30'h00000000;
      step_o     <= 1'b0;
      fullstep_o <= 1'b0;
      pos        <= 32'sh00000000;
    end
    else if (ref_tick && v_mag != 12'h000 && next_vel_acc >= {1'b0, vel_thr})
    begin
      vel_acc    <= 30'(next_vel_acc - {1'b0, vel_thr});
      step_o     <= 1'b1;
      pos        <= next_pos;
      fullstep_o <= (next_pos & mstep_mask) == 32'h00000000;
    end
    else
    begin
      vel_acc    <= ref_tick ? 30'(next_vel_acc) : vel_acc;
      step_o     <= 1'b0;
      fullstep_o <= 1'b0;
    end
  end

  // direction held while stopped
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      dir_o <= 1'b0;
    else if (v_act != 12'sh000)
      dir_o <= v_act[11];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state != step_rate_pkg::st_idle) || (v_act != 12'sh000);
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
    begin
      case (addr_i)
        `OFS_CTRL:    rdata_o <= {30'h00000000, cfg.mode, 1'b0};
        `OFS_VEL:     rdata_o <= 32'(cfg.vel);
        `OFS_ACCEL:   rdata_o <= {21'h000000, cfg.accel};
        `OFS_PDIV:    rdata_o <= {28'h0000000, cfg.pdiv};
        `OFS_RDIV:    rdata_o <= {28'h0000000, cfg.rdiv};
        `OFS_MSTEP:   rdata_o <= {28'h0000000, cfg.mstep_exp};
        `OFS_TARGET:  rdata_o <= target;
        `OFS_ACT_VEL: rdata_o <= 32'(v_act);
        `OFS_POS:     rdata_o <= pos;
        `OFS_LIMITS:  rdata_o <= {5'h00, acc_hi, 5'h00, acc_lo};
        `OFS_STATUS:  rdata_o <= {28'h0000000, state, dir_o, busy_o};
        default:      rdata_o <= 32'h00000000;
      endcase
    end
    else
      rdata_o <= 32'h00000000;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_vel_bounds: assert property (
    v_act <= `VEL_MAX && v_act >= `VEL_MIN && cfg.vel >= `VEL_MIN)
    else $error("velocity outside signed range");

  chk_step_moves_pos: assert property (
    !$past(srst_i) |-> (step_o == (pos != $past(pos))))
    else $error("step pulse and position disagree");

  chk_pdiv_range: assert property (
    cfg.pdiv <= `PDIV_MAX && cfg.rdiv <= `RDIV_MAX)
    else $error("divisor out of range");

  chk_fullstep_align: assert property (
    fullstep_o |-> step_o && ((pos & mstep_mask) == 32'h00000000))
    else $error("fullstep pulse misaligned");

  chk_ramp_unit_step: assert property (
    $changed(v_act) && v_act != 12'sh000 |-> $past(ramp_carry)
      && (v_act - $past(v_act) == 12'sh001 || $past(v_act) - v_act == 12'sh001))
    else $error("velocity moved without ramp carry");

  chk_pos_accel_window: assert property (
    cfg.mode == step_rate_pkg::mode_position |-> acc_eff >= acc_lo && acc_eff <= acc_hi)
    else $error("positioning accel outside window");

  chk_upper_cap: assert property (
    {1'b0, cfg.rdiv} + 5'h01 >= {1'b0, cfg.pdiv} |-> acc_hi == `ACC_MAX)
    else $error("upper accel bound not capped");

  chk_vel_mode_accel: assert property (
    cfg.mode == step_rate_pkg::mode_velocity |-> acc_eff == cfg.accel)
    else $error("velocity mode accel restricted");

  chk_mstep_reset: assert property (
    disable iff (1'b0) $past(srst_i) && !srst_i |-> cfg.mstep_exp == `MSTEP_RST)
    else $error("microstep exponent not 8 after reset");

  chk_dir_sign: assert property (
    step_o |-> (dir_o ? pos == $past(pos) - 32'sh00000001
                      : pos == $past(pos) + 32'sh00000001))
    else $error("step direction disagrees with position");

endmodule : step_rate_ramp_scaling

`default_nettype wire

// ===== step_rate_map.svh
`ifndef STEP_RATE_MAP_SVH
`define STEP_RATE_MAP_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_VEL         8'h04
`define OFS_ACCEL       8'h08
`define OFS_PDIV        8'h0C
`define OFS_RDIV        8'h10
`define OFS_MSTEP       8'h14
`define OFS_TARGET      8'h18
`define OFS_ACT_VEL     8'h1C
`define OFS_POS         8'h20
`define OFS_LIMITS      8'h24
`define OFS_STATUS      8'h28

// control and limits register fields
`define CTRL_START_BIT  0
`define CTRL_MODE_BIT   1
`define CTRL_STOP_BIT   2
`define LIM_HI_LSB      16

// value ranges and reset values
`define VEL_MAX         12'sh7FF
`define VEL_MIN         12'sh801
`define ACC_MAX         11'h7FF
`define PDIV_MAX        4'hD
`define RDIV_MAX        4'hD
`define MSTEP_MAX       4'h8
`define MSTEP_RST       4'h8
`define PDIV_RST        4'h0
`define RDIV_RST        4'h0

// scaling exponents: 2048 * 32 = 2^16, ramp 29 - 16 = 13
`define VEL_FRAC_BITS   5'h10
`define RAMP_BASE_BITS  5'h0D
`define LIM_LO_OFS      6'sh01
`define LIM_HI_OFS      6'sh0C

// reference rate generation
`define REF_KHZ         16000
`define CLK_KHZ         25000

`endif

// ===== step_rate_pkg.sv
package step_rate_pkg;

  typedef enum logic {
    mode_velocity,
    mode_position
  } move_mode_t;

  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_stop
  } motion_state_t;

  typedef struct packed {
    move_mode_t         mode;
    logic signed [11:0] vel;
    logic [10:0]        accel;
    logic [3:0]         pdiv;
    logic [3:0]         rdiv;
    logic [3:0]         mstep_exp;
  } cfg_t;

endpackage : step_rate_pkg

// ===== step_motor_model.sv
`timescale 1ns/10ps
`default_nettype none

module step_motor_model (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  input  wire logic        fullstep_i,
  output var  logic [31:0] pos_o,
  output var  logic [31:0] steps_o,
  output var  logic [31:0] full_o
);
  // driver side: one microstep per pulse, direction taken with it
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pos_o   <= 32'h0;
      steps_o <= 32'h0;
      full_o  <= 32'h0;
    end
    else if (step_i)
    begin
      pos_o   <= dir_i ? pos_o - 32'h1 : pos_o + 32'h1;
      steps_o <= steps_o + 32'h1;
      full_o  <= full_o + {31'h0, fullstep_i};
    end
  end
endmodule : step_motor_model

`default_nettype wire

// ===== test_step_rate_ramp_scaling.sv
`timescale 1ns/10ps
`default_nettype none
`include "step_rate_map.svh"

module test_step_rate_ramp_scaling;
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wdata_i    = 32'h0;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [31:0] rdata_o;
  logic        step_o;
  logic        dir_o;
  logic        fullstep_o;
  logic        busy_o;
  logic [31:0] pos;
  logic [31:0] steps;
  logic [31:0] full;
  logic [31:0] d;
  logic [31:0] s0;
  int          error_cnt  = 0;
  int          checked    = 0;
  int          i;
  // limit table: pulse prescale, ramp prescale, lower and upper bound
  logic [3:0]  pd [6] = '{4'h0, 4'h3, 4'h0, 4'h2, 4'hD, 4'h1};
  logic [3:0]  rp [6] = '{4'h0, 4'h0, 4'h5, 4'h5, 4'h0, 4'hC};
  logic [10:0] lo [6] = '{11'h000, 11'h000, 11'h010, 11'h004, 11'h000, 11'h400};
  logic [10:0] hi [6] = '{11'h7FF, 11'h1FF, 11'h7FF, 11'h7FF, 11'h000, 11'h7FF};

  step_rate_ramp_scaling uut (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .addr_i     (addr_i),
    .wdata_i    (wdata_i),
    .wr_i       (wr_i),
    .rd_i       (rd_i),
    .rdata_o    (rdata_o),
    .step_o     (step_o),
    .dir_o      (dir_o),
    .fullstep_o (fullstep_o),
    .busy_o     (busy_o)
  );

  step_motor_model drv (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .step_i     (step_o),
    .dir_i      (dir_o),
    .fullstep_i (fullstep_o),
    .pos_o      (pos),
    .steps_o    (steps),
    .full_o     (full)
  );

  always #20 core_clk_i = ~core_clk_i;

  task automatic rst;
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
  endtask : rst

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : cmp

  task automatic rng(input logic [31:0] got, input logic [31:0] l, input logic [31:0] h,
                     input string m);
    checked++;
    if ((got >= l && got <= h) !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0d", $time, m, got);
    end
  endtask : rng

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a, d);
    cmp(d, e, m);
  endtask : rdc

  // bounded wait for the motion to settle
  task automatic wait_idle;
    i = 0;
    while (busy_o !== 1'b0 && i < 20000)
    begin
      @(posedge core_clk_i);
      i++;
    end
  endtask : wait_idle

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    #4000000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    rst();
    cmp({28'h0, step_o, dir_o, fullstep_o, busy_o}, 32'h0, "outputs idle");
    rdc(`OFS_MSTEP, 32'h8, "mstep reset");
    @(posedge core_clk_i);
    #1;
    cmp(rdata_o, 32'h0, "rdata idle");
    rdc(`OFS_PDIV, 32'h0, "pdiv reset");
    rdc(`OFS_VEL, 32'h0, "vel reset");
    rdc(8'h3C, 32'h0, "unmapped read");
    $display("test reset done");
    wr(`OFS_VEL, 32'hFFFF_F800);
    rdc(`OFS_VEL, 32'hFFFF_F801, "vel clamp");
    wr(`OFS_VEL, 32'h0000_07FF);
    rdc(`OFS_VEL, 32'h0000_07FF, "vel max");
    wr(`OFS_PDIV, 32'hF);
    rdc(`OFS_PDIV, 32'hD, "pdiv clamp");
    wr(`OFS_MSTEP, 32'h9);
    rdc(`OFS_MSTEP, 32'h8, "mstep clamp");
    wr(`OFS_ACCEL, 32'hFFFF);
    wr(8'h3C, 32'h1);
    rdc(`OFS_ACCEL, 32'h7FF, "accel field");
    $display("test clamp done");
    wr(`OFS_CTRL, 32'h2);
    for (i = 0; i < 6; i++)
    begin
      wr(`OFS_PDIV, {28'h0, pd[i]});
      wr(`OFS_RDIV, {28'h0, rp[i]});
      rdc(`OFS_LIMITS, {5'h0, hi[i], 5'h0, lo[i]}, "limits");
    end
    $display("test limits done");
    rst();
    wr(`OFS_MSTEP, 32'h2);
    wr(`OFS_PDIV, 32'h0);
    wr(`OFS_ACCEL, 32'h7FF);
    wr(`OFS_VEL, 32'h7FF);
    wr(`OFS_CTRL, 32'h1);
    i = 0;
    d = 32'h0;
    while (d !== 32'h7FF && i < 1500)
    begin
      repeat (20) @(posedge core_clk_i);
      rd(`OFS_ACT_VEL, d);
      i++;
    end
    cmp(d, 32'h7FF, "ramp top");
    rdc(`OFS_STATUS, 32'h5, "status run");
    cmp({31'h0, dir_o}, 32'h0, "dir positive");
    cmp({31'h0, busy_o}, 32'h1, "busy run");
    s0 = steps;
    repeat (25000) @(posedge core_clk_i);
    #1;
    rng(steps - s0, 32'h1F3, 32'h1F4, "step rate");
    cmp(full, steps >> 2, "fullstep ratio");
    wr(`OFS_CTRL, 32'h4);
    rdc(`OFS_STATUS, 32'h9, "status stop");
    wait_idle();
    cmp({31'h0, busy_o}, 32'h0, "stop idle");
    rdc(`OFS_ACT_VEL, 32'h0, "stop ramp");
    $display("test velocity done");
    rst();
    wr(`OFS_ACCEL, 32'h7FF);
    wr(`OFS_VEL, 32'h7FF);
    wr(`OFS_TARGET, 32'hFFFF_FFF8);
    wr(`OFS_CTRL, 32'h3);
    repeat (2) @(posedge core_clk_i);
    wait_idle();
    rdc(`OFS_POS, 32'hFFFF_FFF8, "pos target");
    cmp(pos, 32'hFFFF_FFF8, "driver pos");
    cmp({31'h0, dir_o}, 32'h1, "dir negative");
    rdc(`OFS_ACT_VEL, 32'h0, "stopped");
    $display("test positioning done");
    summarize();
  end
endmodule : test_step_rate_ramp_scaling

`default_nettype wire
